// file: src/tws_pkg.sv
// Purpose: shared constants of the two-wire serial slave framing block
// Assumes: system clock of 100 MHz
// Notes: times are kept in their own unit, cycle counts derive from them
package tws_pkg;
    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TWR_MS = 5;
    localparam int unsigned NS_PER_MS = 1_000_000;
    // longest time, so rounded down
    localparam int unsigned TWR_CYC = TWR_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned TWR_CNT_W = 20;

    // ==========================================================
    // word framing
    localparam int unsigned WORD_BITS = 8;
    localparam int unsigned BIT_CNT_W = 4;
    localparam logic [3:0] LAST_DATA_CNT = 4'h7;
    localparam logic [3:0] ACK_CNT = 4'h8;
    localparam logic [2:0] MSB_IDX = 3'h7;
    localparam int unsigned SYNC_W = 6;

    // ==========================================================
    // reset values
    localparam logic [7:0] TX_RESET = 8'hff;
    localparam logic [8:0] RX_RESET = 9'h000;
endpackage

// file: src/tws_sync.sv
// Purpose: two flip-flop synchroniser for a bus of levels
// Assumes: each bit is a level or a toggle, never a multi-bit word
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module tws_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_q;

    // ==========================================================
    // two stages
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule

// file: src/tws_slave.sv
// Purpose: bit framing of a two-wire serial slave port
// Assumes: serial clock is a clock port, far slower than i_sys_clk
// Notes: link logic runs on i_scl, control on i_sys_clk
//
// Summary of operation
// - data changes only with clock low; changes while high mean start/stop.
// - data falling while clock high is a start, detected in any state.
// - data rising while clock high is a stop, ending the transfer.
// - a stop after a read sequence puts the device into standby.
// - every address and data item is an 8-bit serial word.
// - device pulls data low in the ninth clock to acknowledge a word.
// - data line is only pulled low or released, never driven high.
// - input bits sampled on clock rise, read data launched on clock fall.
// - busy period is counted from the stop that ends a write.
`timescale 1ns/1ps
module tws_slave #(
    parameter int unsigned TWR_CYCLES = tws_pkg::TWR_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda_i,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic [7:0] o_rx_data,
    output logic o_rx_cmd,
    output logic o_rx_valid,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_load,
    output logic o_tx_taken,
    output logic o_start,
    output logic o_stop,
    output logic o_standby,
    output logic o_busy
);
    // ==========================================================
    // declarations
    logic link_hold_q;
    logic arm_q;
    logic link_rst_n;
    logic [tws_pkg::BIT_CNT_W-1:0] cnt_q;
    logic [6:0] sh_q;
    logic first_q;
    logic rd_pend_q;
    logic rd_mode_q;
    logic rd_halt_q;
    logic wr_seen_q;
    logic [8:0] rx_q;
    logic rx_tgl_q;
    logic tx_tgl_q;
    logic [7:0] tx_q;
    logic [7:0] tx_hold_q;
    logic [7:0] tx_word;
    logic bsy_meta_q;
    logic bsy_l_q;
    logic oe_q;
    logic sda_o_q;
    logic [tws_pkg::SYNC_W-1:0] sync_in;
    logic [tws_pkg::SYNC_W-1:0] sync_q;
    logic scl_s, sda_s, rd_s, wr_s, rxt_s, txt_s;
    logic scl_p_q, sda_p_q, rxt_p_q, txt_p_q;
    logic start_p, stop_p;
    logic [tws_pkg::TWR_CNT_W-1:0] twr_cnt_q;
    logic busy_q;
    logic standby_q;
    logic [7:0] rx_data_q;
    logic rx_cmd_q, rx_valid_q, tx_taken_q, start_q, stop_q;

    // ==========================================================
    // system side: pin and toggle synchronisers
    assign sync_in = {i_scl, i_sda_i, rd_mode_q, wr_seen_q, rx_tgl_q,
                      tx_tgl_q};

    tws_sync #(
        .WIDTH(tws_pkg::SYNC_W)
    ) u_sync (
        .i_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_d(sync_in),
        .o_q(sync_q)
    );

    assign {scl_s, sda_s, rd_s, wr_s, rxt_s, txt_s} = sync_q;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            rxt_p_q <= 1'b0;
            txt_p_q <= 1'b0;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            rxt_p_q <= rxt_s;
            txt_p_q <= txt_s;
        end
    end

    // ==========================================================
    // start and stop detection
    assign start_p = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_p = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // link logic held in reset between frames; a start re-arms it and
    // the first clock fall after the start releases it, well before
    // the first rising edge of the frame
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            link_hold_q <= 1'b1;
            arm_q <= 1'b0;
        end else if (start_p) begin
            link_hold_q <= 1'b1;
            arm_q <= 1'b1;
        end else if (stop_p) begin
            link_hold_q <= 1'b1;
            arm_q <= 1'b0;
        end else if (arm_q && scl_p_q && !scl_s) begin
            link_hold_q <= 1'b0;
            arm_q <= 1'b0;
        end
    end

    assign link_rst_n = i_resetn & ~link_hold_q;

    // ==========================================================
    // standby and write busy
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            standby_q <= 1'b0;
        end else if (start_p) begin
            standby_q <= 1'b0;
        end else if (stop_p && rd_s) begin
            standby_q <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_q <= 1'b0;
            twr_cnt_q <= '0;
        end else if (stop_p && wr_s && !busy_q) begin
            busy_q <= 1'b1;
            twr_cnt_q <= tws_pkg::TWR_CNT_W'(TWR_CYCLES - 1);
        end else if (busy_q) begin
            if (twr_cnt_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                twr_cnt_q <= twr_cnt_q - 1'b1;
            end
        end
    end

    // ==========================================================
    // user side word handshakes
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_data_q <= '0;
            rx_cmd_q <= 1'b0;
            rx_valid_q <= 1'b0;
        end else begin
            rx_valid_q <= rxt_s ^ rxt_p_q;
            if (rxt_s ^ rxt_p_q) begin
                // word register is stable for nine serial clocks
                rx_data_q <= rx_q[7:0];
                rx_cmd_q <= rx_q[8];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_hold_q <= tws_pkg::TX_RESET;
            tx_taken_q <= 1'b0;
        end else begin
            tx_taken_q <= txt_s ^ txt_p_q;
            if (i_tx_load) begin
                tx_hold_q <= i_tx_data;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            start_q <= 1'b0;
            stop_q <= 1'b0;
            sda_o_q <= 1'b0;
        end else begin
            start_q <= start_p;
            stop_q <= stop_p;
            sda_o_q <= 1'b0;
        end
    end

    // ==========================================================
    // link side: receive on the rising edge
    always_ff @(posedge i_scl or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cnt_q <= '0;
            sh_q <= '0;
        end else begin
            sh_q <= {sh_q[5:0], i_sda_i};
            if (cnt_q == tws_pkg::ACK_CNT) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_scl or negedge link_rst_n) begin
        if (!link_rst_n) begin
            first_q <= 1'b1;
            rd_pend_q <= 1'b0;
            rd_mode_q <= 1'b0;
            rd_halt_q <= 1'b0;
            wr_seen_q <= 1'b0;
        end else begin
            if (first_q && cnt_q == tws_pkg::LAST_DATA_CNT) begin
                rd_pend_q <= i_sda_i;
            end
            if (cnt_q == tws_pkg::ACK_CNT) begin
                first_q <= 1'b0;
                if (first_q && rd_pend_q && !bsy_l_q) begin
                    rd_mode_q <= 1'b1;
                end
                if (!first_q && !rd_mode_q && !bsy_l_q) begin
                    wr_seen_q <= 1'b1;
                end
                if (rd_mode_q && i_sda_i) begin
                    rd_halt_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_scl or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_q <= tws_pkg::RX_RESET;
            rx_tgl_q <= 1'b0;
            bsy_meta_q <= 1'b0;
            bsy_l_q <= 1'b0;
        end else begin
            bsy_meta_q <= busy_q;
            bsy_l_q <= bsy_meta_q;
            if (cnt_q == tws_pkg::LAST_DATA_CNT && !rd_mode_q &&
                link_rst_n) begin
                rx_q <= {first_q, sh_q, i_sda_i};
                rx_tgl_q <= ~rx_tgl_q;
            end
        end
    end

    // ==========================================================
    // link side: drive on the falling edge
    assign tx_word = (cnt_q == '0) ? tx_hold_q : tx_q;

    always_ff @(negedge i_scl or negedge link_rst_n) begin
        if (!link_rst_n) begin
            oe_q <= 1'b0;
            tx_q <= tws_pkg::TX_RESET;
        end else begin
            if (cnt_q == '0 && rd_mode_q) begin
                tx_q <= tx_hold_q;
            end
            if (cnt_q == tws_pkg::ACK_CNT) begin
                // busy device stays silent so the host polls
                oe_q <= ~rd_mode_q & ~bsy_l_q;
            end else if (rd_mode_q && !rd_halt_q) begin
                oe_q <= ~tx_word[tws_pkg::MSB_IDX - cnt_q[2:0]];
            end else begin
                oe_q <= 1'b0;
            end
        end
    end

    always_ff @(negedge i_scl or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_tgl_q <= 1'b0;
        end else if (link_rst_n && cnt_q == '0 && rd_mode_q &&
                     !rd_halt_q) begin
            tx_tgl_q <= ~tx_tgl_q;
        end
    end

    // ==========================================================
    // outputs
    assign o_sda_o = sda_o_q;
    assign o_sda_oe = oe_q;
    assign o_rx_data = rx_data_q;
    assign o_rx_cmd = rx_cmd_q;
    assign o_rx_valid = rx_valid_q;
    assign o_tx_taken = tx_taken_q;
    assign o_start = start_q;
    assign o_stop = stop_q;
    assign o_standby = standby_q;
    assign o_busy = busy_q;
endmodule

// file: tb/tws_host.sv
// Purpose: host bus master model driving the serial clock and data
// Assumes: data wire has a pull-up, clock idles high between frames
// Notes: HALF_NS is half a serial clock period
`timescale 1ns/1ps
module tws_host #(
    parameter int HALF_NS = 250
) (
    output logic o_scl,
    output logic o_sda_oe,
    input wire logic i_sda
);
    // ====
    // frame tasks
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic start();
        #HALF_NS o_sda_oe = 1'b1;
        #HALF_NS o_scl = 1'b0;
    endtask
    task automatic stop();
        #(HALF_NS/2) o_sda_oe = 1'b1;
        #(HALF_NS/2) o_scl = 1'b1;
        #HALF_NS o_sda_oe = 1'b0;
        #HALF_NS;
    endtask
    task automatic bit_out(input logic b);
        #(HALF_NS/2) o_sda_oe = ~b;
        #(HALF_NS/2) o_scl = 1'b1;
        #HALF_NS o_scl = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_out(b[i]);
        end
        #(HALF_NS/2) o_sda_oe = 1'b0;
        #(HALF_NS/2) o_scl = 1'b1;
        #(HALF_NS/2) ack = ~i_sda;
        #(HALF_NS/2) o_scl = 1'b0;
    endtask
    task automatic get_byte(input logic ack, output logic [7:0] b);
        // data already released by the previous word's last step
        for (int i = 7; i >= 0; i--) begin
            #HALF_NS o_scl = 1'b1;
            #(HALF_NS/2) b[i] = i_sda;
            #(HALF_NS/2) o_scl = 1'b0;
        end
        bit_out(~ack);
        #(HALF_NS/2) o_sda_oe = 1'b0;
    endtask
endmodule

// file: tb/tws_slave_checker.sv
// Purpose: port checks of the two-wire slave framing
// Assumes: link pins sampled on the system clock
// Notes: bound into every tws_slave
`timescale 1ns/1ps
module tws_slave_checker #(
    parameter int unsigned TWR_CYCLES = 50
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda_i,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire logic o_rx_valid,
    input wire logic o_start,
    input wire logic o_stop,
    input wire logic o_standby,
    input wire logic o_busy
);
    // ====
    // busy length counter
    logic [31:0] busy_cnt_q;
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_cnt_q <= '0;
        end else begin
            busy_cnt_q <= o_busy ? busy_cnt_q + 32'h0000_0001 : '0;
        end
    end
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);
    property p_lo; o_sda_o == 1'b0; endproperty
    a_lo: assert property (p_lo) else $error("data driven high");
    property p_oe; $changed(o_sda_oe) |-> !i_scl; endproperty
    a_oe: assert property (p_oe) else $error("oe moved, clk high");
    property p_sta; $fell(i_sda_i) && i_scl |-> ##[1:6] o_start; endproperty
    a_sta: assert property (p_sta) else $error("start missed");
    property p_sto; $rose(i_sda_i) && i_scl |-> ##[1:6] o_stop; endproperty
    a_sto: assert property (p_sto) else $error("stop missed");
    property p_sb; $rose(o_standby) |-> o_stop || $past(o_stop); endproperty
    a_sb: assert property (p_sb) else $error("standby w/o stop");
    property p_bz; $rose(o_busy) |-> o_stop || $past(o_stop); endproperty
    a_bz: assert property (p_bz) else $error("busy w/o stop");
    property p_len;
        $fell(o_busy) |-> busy_cnt_q inside {[TWR_CYCLES:TWR_CYCLES + 1]};
    endproperty
    a_len: assert property (p_len) else $error("busy length");
    property p_nak; o_busy |-> !o_sda_oe; endproperty
    a_nak: assert property (p_nak) else $error("ack while busy");
    property p_rv; o_rx_valid |=> !o_rx_valid; endproperty
    a_rv: assert property (p_rv) else $error("rx valid held");
    c_sb: cover property ($rose(o_standby));
    c_poll: cover property (o_busy && o_start);
    c_done: cover property ($fell(o_busy));
endmodule
bind tws_slave tws_slave_checker #(.TWR_CYCLES(TWR_CYCLES)) u_chk (.*);

// file: tb/test_two_wire_serial_slave_framing.sv
// Purpose: self-checking bench of the two-wire slave framing
// Assumes: host model drives the link, bench drives the sys side
// Notes: short write cycle so busy ends inside the run
`timescale 1ns/1ps
module test_two_wire_serial_slave_framing;
    localparam int unsigned TWR = 2000;
    logic i_sys_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_scl, host_oe, o_sda_o, o_sda_oe, o_rx_cmd, o_rx_valid;
    logic o_tx_taken, o_start, o_stop, o_standby, o_busy;
    logic [7:0] o_rx_data;
    logic [7:0] i_tx_data = 8'h00;
    logic i_tx_load = 1'b0;
    wire i_sda_i = ~(host_oe | o_sda_oe);
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [8:0] rx_q[$];
    always #5 i_sys_clk = ~i_sys_clk;
    tws_slave #(.TWR_CYCLES(TWR)) dut (.*);
    tws_host host (.o_scl(i_scl), .o_sda_oe(host_oe), .i_sda(i_sda_i));
    // ====
    // monitor, timeout and shared tasks
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (o_rx_valid === 1'b1) begin
            rx_q.push_back({o_rx_cmd, o_rx_data});
        end
        if (cycles == 60000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [8:0] e, g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        if (fails == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic load(input logic [7:0] d);
        @(negedge i_sys_clk);
        i_tx_data = d;
        i_tx_load = 1'b1;
        @(negedge i_sys_clk);
        i_tx_load = 1'b0;
    endtask
    task automatic t_read();
        logic ack;
        logic [7:0] b0, b1;
        load(8'hc3);
        host.start();
        host.put_byte(8'ha5, ack);
        chk("cmd ack", 9'h001, {8'h00, ack});
        fork
            host.get_byte(1'b1, b0);
            begin
                for (int i = 0; i < 900 && o_tx_taken !== 1'b1; i++) begin
                    @(negedge i_sys_clk);
                end
                chk("tx taken", 9'h001, {8'h00, o_tx_taken});
                load(8'h3c);
            end
        join
        host.get_byte(1'b0, b1);
        host.stop();
        repeat (8) @(negedge i_sys_clk);
        chk("read 0", 9'h0c3, {1'b0, b0});
        chk("read 1", 9'h03c, {1'b0, b1});
        chk("standby", 9'h001, {8'h00, o_standby});
        chk("rx cmd", 9'h1a5, rx_q.pop_front());
    endtask
    task automatic t_write();
        logic ack;
        host.start();
        repeat (8) @(negedge i_sys_clk);
        chk("standby clr", 9'h000, {8'h00, o_standby});
        host.put_byte(8'ha4, ack);
        host.put_byte(8'h5b, ack);
        chk("data ack", 9'h001, {8'h00, ack});
        host.stop();
        repeat (8) @(negedge i_sys_clk);
        chk("busy", 9'h002, {7'h00, o_busy, o_standby});
        chk("rx cmd", 9'h1a4, rx_q.pop_front());
        chk("rx data", 9'h05b, rx_q.pop_front());
        host.start();
        host.put_byte(8'ha5, ack);
        host.stop();
        chk("busy nack", 9'h000, {8'h00, ack});
        chk("busy no sb", 9'h000, {8'h00, o_standby});
        for (int i = 0; i < TWR && o_busy === 1'b1; i++) begin
            @(negedge i_sys_clk);
        end
        chk("busy end", 9'h000, {8'h00, o_busy});
        host.start();
        host.put_byte(8'ha4, ack);
        host.stop();
        chk("poll ack", 9'h001, {8'h00, ack});
    endtask
    initial begin
        repeat (16) @(negedge i_sys_clk);
        i_resetn = 1'b1;
        chk("idle", 9'h000, {6'h00, o_sda_oe, o_busy, o_standby});
        repeat (4) @(negedge i_sys_clk);
        t_read();
        t_write();
        report_and_stop();
    end
endmodule
